// *** core/serial_port_control_flags.v ***
// Purpose: Serial port control, flags, address filter and APB registers
// Assumes: APB slave with one wait state; inputs synchronous to ref_clk
// Notes: Shift-register mode drives data on the rxd pin and clock on txd
`timescale 1ns/1ns
`include "serial_port_regs.vh"

module serial_port_control_flags (
	input wire ref_clk,
	input wire nrst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire rxd_in,
	output reg rxd_out,
	output reg rxd_oe,
	output reg txd_out,
	output reg irq
);
	// Control and power bits, byte registers, interrupt fields, start strobe and tick state
	reg mode_select_low_reg;
	reg mode_select_high_reg;
	reg multiproc_filter_enable_reg;
	reg rx_enable_reg;
	reg tx_ninth_bit_reg;
	reg rx_ninth_bit_reg;
	reg tx_done_flag_reg;
	reg rx_done_flag_reg;
	reg frame_error_flag_reg;
	reg double_rate_select_reg;
	reg frame_error_access_select_reg;
	reg [7:0] serial_buffer_reg;
	reg [7:0] tx_data_reg;
	reg [7:0] own_addr_reg;
	reg [7:0] addr_mask_reg;
	reg [7:0] bcast_addr_reg;
	reg [7:0] baud_reload_reg;
	reg [2:0] int_status_reg;
	reg [2:0] int_mask_reg;
	reg tx_start_reg;
	reg [7:0] baud_cnt_reg;
	reg baud_half_reg;
	reg fixed_div_reg;
	reg tick_reg;

	reg [31:0] rd_data;
	reg rd_hit;
	reg tx_done_next;
	reg rx_done_next;
	reg frame_error_next;
	reg rx_ninth_next;
	reg [2:0] int_status_next;
	reg rx_accept;

	wire [1:0] mode;
	wire access;
	wire wr_en;
	wire rd_en;
	wire tx_busy;
	wire tx_done_pulse;
	wire tx_ser;
	wire tx_sclk;
	wire rx_done_pulse;
	wire [7:0] rx_byte;
	wire rx_ninth;
	wire rx_stop_ok;
	wire rx_sclk;
	wire addr_match;
	wire reload_hit;

	assign mode = {mode_select_low_reg, mode_select_high_reg};
	assign access = psel & penable & pready;
	assign wr_en = access & pwrite;
	assign rd_en = access & ~pwrite;

	// Address filter with don't-care mask
	assign addr_match = (((rx_byte ^ own_addr_reg) & ~addr_mask_reg) == 8'h00) ||
		(((rx_byte ^ bcast_addr_reg) & ~addr_mask_reg) == 8'h00);

	// Oversample tick: fixed rate from ref_clk, variable rate from reload counter
	assign reload_hit = (baud_cnt_reg == 8'hff);

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			baud_cnt_reg <= 8'h00;
			baud_half_reg <= 1'b0;
			fixed_div_reg <= 1'b0;
			tick_reg <= 1'b0;
		end else begin
			fixed_div_reg <= ~fixed_div_reg;
			baud_cnt_reg <= reload_hit ? baud_reload_reg : baud_cnt_reg + 8'h01;
			if (reload_hit)
				baud_half_reg <= ~baud_half_reg;
			case (mode)
				`MODE_UART9_FIXED: tick_reg <= double_rate_select_reg | fixed_div_reg;
				`MODE_UART8, `MODE_UART9_VAR:
					tick_reg <= reload_hit & (double_rate_select_reg | baud_half_reg);
				default: tick_reg <= 1'b0;
			endcase
		end
	end

	serial_tx_shift u_tx (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.mode(mode),
		.tick(tick_reg),
		.start(tx_start_reg),
		.data(tx_data_reg),
		.ninth(tx_ninth_bit_reg),
		.busy(tx_busy),
		.done(tx_done_pulse),
		.ser_out(tx_ser),
		.sclk(tx_sclk)
	);

	serial_rx_shift u_rx (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.mode(mode),
		.tick(tick_reg),
		.enable(rx_enable_reg),
		.start_shift(~rx_done_flag_reg & ~tx_busy),
		.rx_in(rxd_in),
		.busy(),
		.done(rx_done_pulse),
		.data(rx_byte),
		.ninth(rx_ninth),
		.stop_ok(rx_stop_ok),
		.sclk(rx_sclk)
	);

	// Receive acceptance and flag updates; hardware set wins over software write
	always @* begin
		rx_accept = 1'b0;
		rx_ninth_next = rx_ninth_bit_reg;
		frame_error_next = frame_error_flag_reg;
		if (wr_en && paddr == `OFF_SERIAL_PORT_CONTROL) begin
			rx_ninth_next = pwdata[`CTL_RX_NINTH];
			if (frame_error_access_select_reg)
				frame_error_next = pwdata[`CTL_MODE_LOW_FE];
		end
		if (rx_done_pulse) begin
			case (mode)
				`MODE_SHIFT: rx_accept = 1'b1;
				`MODE_UART8: begin
					rx_accept = ~multiproc_filter_enable_reg |
						(rx_stop_ok & addr_match);
					if (!multiproc_filter_enable_reg)
						rx_ninth_next = rx_stop_ok;
				end
				default: begin
					rx_accept = ~multiproc_filter_enable_reg |
						(rx_ninth & addr_match);
					rx_ninth_next = rx_ninth;
				end
			endcase
			if (mode != `MODE_SHIFT && !rx_stop_ok)
				frame_error_next = 1'b1;
		end
		tx_done_next = tx_done_flag_reg;
		rx_done_next = rx_done_flag_reg;
		if (wr_en && paddr == `OFF_SERIAL_PORT_CONTROL) begin
			tx_done_next = pwdata[`CTL_TX_DONE];
			rx_done_next = pwdata[`CTL_RX_DONE];
		end
		if (tx_done_pulse)
			tx_done_next = 1'b1;
		if (rx_accept)
			rx_done_next = 1'b1;
		int_status_next = int_status_reg;
		if (rd_en && paddr == `OFF_INT_STATUS)
			int_status_next = `RST_INT;
		if (tx_done_pulse)
			int_status_next[`INT_TX_DONE] = 1'b1;
		if (rx_accept)
			int_status_next[`INT_RX_DONE] = 1'b1;
		if (rx_done_pulse && mode != `MODE_SHIFT && !rx_stop_ok)
			int_status_next[`INT_FRAME_ERR] = 1'b1;
	end

	// Read mux
	always @* begin
		rd_data = 32'h00000000;
		rd_hit = 1'b1;
		case (paddr)
			`OFF_SERIAL_PORT_CONTROL: rd_data[7:0] = {
				frame_error_access_select_reg ? frame_error_flag_reg :
					mode_select_low_reg,
				mode_select_high_reg, multiproc_filter_enable_reg, rx_enable_reg,
				tx_ninth_bit_reg, rx_ninth_bit_reg, tx_done_flag_reg, rx_done_flag_reg};
			`OFF_SERIAL_BUFFER: rd_data[7:0] = serial_buffer_reg;
			`OFF_POWER_CONTROL: rd_data[7:0] = {double_rate_select_reg,
				frame_error_access_select_reg, 6'h00};
			`OFF_OWN_ADDR: rd_data[7:0] = own_addr_reg;
			`OFF_ADDR_MASK: rd_data[7:0] = addr_mask_reg;
			`OFF_BCAST_ADDR: rd_data[7:0] = bcast_addr_reg;
			`OFF_BAUD_RELOAD: rd_data[7:0] = baud_reload_reg;
			`OFF_INT_STATUS: rd_data[2:0] = int_status_reg;
			`OFF_INT_MASK: rd_data[2:0] = int_mask_reg;
			default: rd_hit = 1'b0;
		endcase
	end

	// APB answer: pready rises in the second access cycle
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~rd_hit;
			if (psel && penable && !pready && !pwrite)
				prdata <= rd_data;
			else if (access)
				prdata <= 32'h00000000;
		end
	end

	// Register file
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			mode_select_low_reg <= 1'b0;
			mode_select_high_reg <= 1'b0;
			multiproc_filter_enable_reg <= 1'b0;
			rx_enable_reg <= 1'b0;
			tx_ninth_bit_reg <= 1'b0;
			rx_ninth_bit_reg <= 1'b0;
			tx_done_flag_reg <= 1'b0;
			rx_done_flag_reg <= 1'b0;
			frame_error_flag_reg <= 1'b0;
			double_rate_select_reg <= 1'b0;
			frame_error_access_select_reg <= 1'b0;
			serial_buffer_reg <= `RST_BYTE;
			tx_data_reg <= `RST_BYTE;
			own_addr_reg <= `RST_BYTE;
			addr_mask_reg <= `RST_BYTE;
			bcast_addr_reg <= `RST_BYTE;
			baud_reload_reg <= `RST_BYTE;
			int_status_reg <= `RST_INT;
			int_mask_reg <= `RST_INT;
			tx_start_reg <= 1'b0;
			irq <= 1'b0;
		end else begin
			tx_start_reg <= 1'b0;
			tx_done_flag_reg <= tx_done_next;
			rx_done_flag_reg <= rx_done_next;
			rx_ninth_bit_reg <= rx_ninth_next;
			frame_error_flag_reg <= frame_error_next;
			int_status_reg <= int_status_next;
			irq <= |(int_status_next & int_mask_reg);
			if (rx_accept)
				serial_buffer_reg <= rx_byte;
			if (wr_en) begin
				case (paddr)
					`OFF_SERIAL_PORT_CONTROL: begin
						if (!frame_error_access_select_reg)
							mode_select_low_reg <= pwdata[`CTL_MODE_LOW_FE];
						mode_select_high_reg <= pwdata[`CTL_MODE_HIGH];
						multiproc_filter_enable_reg <= pwdata[`CTL_FILTER];
						rx_enable_reg <= pwdata[`CTL_RX_ENABLE];
						tx_ninth_bit_reg <= pwdata[`CTL_TX_NINTH];
					end
					`OFF_SERIAL_BUFFER: begin
						tx_data_reg <= pwdata[7:0];
						tx_start_reg <= ~tx_busy;
					end
					`OFF_POWER_CONTROL: begin
						double_rate_select_reg <= pwdata[`PWR_DOUBLE_RATE];
						frame_error_access_select_reg <= pwdata[`PWR_FE_ACCESS];
					end
					`OFF_OWN_ADDR: own_addr_reg <= pwdata[7:0];
					`OFF_ADDR_MASK: addr_mask_reg <= pwdata[7:0];
					`OFF_BCAST_ADDR: bcast_addr_reg <= pwdata[7:0];
					`OFF_BAUD_RELOAD: baud_reload_reg <= pwdata[7:0];
					`OFF_INT_MASK: int_mask_reg <= pwdata[2:0];
					default: tx_start_reg <= 1'b0;
				endcase
			end
		end
	end

	// Pin drive: shift mode uses rxd for data and txd for the shift clock
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rxd_out <= 1'b1;
			rxd_oe <= 1'b0;
			txd_out <= 1'b1;
		end else if (mode == `MODE_SHIFT) begin
			rxd_out <= tx_ser;
			// Keep last bit driven through its rising shift clock
			rxd_oe <= tx_busy | (rxd_oe & ~txd_out);
			txd_out <= tx_sclk & rx_sclk;
		end else begin
			rxd_out <= 1'b1;
			rxd_oe <= 1'b0;
			txd_out <= tx_ser;
		end
	end
endmodule // serial_port_control_flags

// *** inc/serial_port_regs.vh ***
// Purpose: Register map, field positions and timing counts of the serial port
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH

`define OFF_SERIAL_PORT_CONTROL 8'h00
`define OFF_SERIAL_BUFFER 8'h04
`define OFF_POWER_CONTROL 8'h08
`define OFF_OWN_ADDR 8'h0c
`define OFF_ADDR_MASK 8'h10
`define OFF_BCAST_ADDR 8'h14
`define OFF_BAUD_RELOAD 8'h18
`define OFF_INT_STATUS 8'h1c
`define OFF_INT_MASK 8'h20

// Control register fields
`define CTL_MODE_LOW_FE 7
`define CTL_MODE_HIGH 6
`define CTL_FILTER 5
`define CTL_RX_ENABLE 4
`define CTL_TX_NINTH 3
`define CTL_RX_NINTH 2
`define CTL_TX_DONE 1
`define CTL_RX_DONE 0

// Power control fields
`define PWR_DOUBLE_RATE 7
`define PWR_FE_ACCESS 6

// Interrupt status fields
`define INT_TX_DONE 0
`define INT_RX_DONE 1
`define INT_FRAME_ERR 2

// Reset values
`define RST_CONTROL 8'h00
`define RST_POWER 8'h00
`define RST_BYTE 8'h00
`define RST_INT 3'h0

// Mode encodings
`define MODE_SHIFT 2'h0
`define MODE_UART8 2'h1
`define MODE_UART9_FIXED 2'h2
`define MODE_UART9_VAR 2'h3

// Timing counts
`define OVERSAMPLE_LAST 4'hf
`define SAMPLE_FIRST 4'h7
`define SAMPLE_SECOND 4'h8
`define SAMPLE_DECIDE 4'h9
`define SHIFT_LAST_BIT 4'h7

`endif

// *** core/serial_tx_shift.v ***
// Purpose: Transmit shifter for shift-register and UART frames
// Assumes: tick is the 16x oversample strobe in UART modes
// Notes: In shift-register mode one bit takes two clocks
`timescale 1ns/1ns
`include "serial_port_regs.vh"

module serial_tx_shift (
	input wire ref_clk,
	input wire nrst,
	input wire [1:0] mode,
	input wire tick,
	input wire start,
	input wire [7:0] data,
	input wire ninth,
	output reg busy,
	output reg done,
	output reg ser_out,
	output reg sclk
);
	reg [10:0] frm;
	reg [3:0] bitn;
	reg [3:0] tk;
	reg ph;
	wire nine_bit;
	wire [3:0] stop_idx;

	assign nine_bit = mode[1];
	assign stop_idx = nine_bit ? 4'ha : 4'h9;

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			busy <= 1'b0;
			done <= 1'b0;
			ser_out <= 1'b1;
			sclk <= 1'b1;
			frm <= 11'h7ff;
			bitn <= 4'h0;
			tk <= 4'h0;
			ph <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy) begin
				ser_out <= 1'b1;
				sclk <= 1'b1;
				if (start) begin
					busy <= 1'b1;
					bitn <= 4'h0;
					tk <= 4'h0;
					ph <= 1'b0;
					if (mode == `MODE_SHIFT)
						frm <= {3'h7, data};
					else if (nine_bit)
						frm <= {1'b1, ninth, data, 1'b0};
					else
						frm <= {2'h3, data, 1'b0};
				end
			end else if (mode == `MODE_SHIFT) begin
				ph <= ~ph;
				if (!ph) begin
					sclk <= 1'b0;
					ser_out <= frm[bitn];
				end else begin
					sclk <= 1'b1;
					if (bitn == `SHIFT_LAST_BIT) begin
						busy <= 1'b0;
						done <= 1'b1;
					end else
						bitn <= bitn + 4'h1;
				end
			end else begin
				ser_out <= frm[bitn];
				if (tick) begin
					tk <= tk + 4'h1;
					if (tk == `OVERSAMPLE_LAST) begin
						if (bitn == stop_idx)
							busy <= 1'b0;
						else begin
							bitn <= bitn + 4'h1;
							if (bitn + 4'h1 == stop_idx)
								done <= 1'b1;
						end
					end
				end
			end
		end
	end
endmodule // serial_tx_shift

// *** core/serial_rx_shift.v ***
// Purpose: Receive shifter for shift-register and UART frames
// Assumes: tick is the 16x oversample strobe in UART modes
// Notes: Majority of three samples decides each UART bit
`timescale 1ns/1ns
`include "serial_port_regs.vh"

module serial_rx_shift (
	input wire ref_clk,
	input wire nrst,
	input wire [1:0] mode,
	input wire tick,
	input wire enable,
	input wire start_shift,
	input wire rx_in,
	output reg busy,
	output reg done,
	output reg [7:0] data,
	output reg ninth,
	output reg stop_ok,
	output reg sclk
);
	reg [7:0] sh;
	reg [3:0] bitn;
	reg [3:0] tk;
	reg [1:0] smp;
	reg ph;
	reg rx_prev;
	wire vote;
	wire [3:0] stop_idx;

	assign vote = (smp[1] & smp[0]) | (smp[1] & rx_in) | (smp[0] & rx_in);
	assign stop_idx = mode[1] ? 4'ha : 4'h9;

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			busy <= 1'b0;
			done <= 1'b0;
			data <= 8'h00;
			ninth <= 1'b0;
			stop_ok <= 1'b0;
			sclk <= 1'b1;
			sh <= 8'h00;
			bitn <= 4'h0;
			tk <= 4'h0;
			smp <= 2'h0;
			ph <= 1'b0;
			rx_prev <= 1'b1;
		end else begin
			done <= 1'b0;
			rx_prev <= rx_in;
			if (!busy) begin
				sclk <= 1'b1;
				bitn <= 4'h0;
				tk <= 4'h0;
				ph <= 1'b0;
				if (mode == `MODE_SHIFT) begin
					if (start_shift && enable)
						busy <= 1'b1;
				end else if (enable && rx_prev && !rx_in)
					busy <= 1'b1;
			end else if (mode == `MODE_SHIFT) begin
				ph <= ~ph;
				if (!ph)
					sclk <= 1'b0;
				else begin
					sclk <= 1'b1;
					sh <= {rx_in, sh[7:1]};
					if (bitn == `SHIFT_LAST_BIT) begin
						busy <= 1'b0;
						done <= 1'b1;
						data <= {rx_in, sh[7:1]};
					end else
						bitn <= bitn + 4'h1;
				end
			end else if (tick) begin
				tk <= tk + 4'h1;
				if (tk == `SAMPLE_FIRST)
					smp[1] <= rx_in;
				if (tk == `SAMPLE_SECOND)
					smp[0] <= rx_in;
				if (tk == `SAMPLE_DECIDE) begin
					if (bitn == 4'h0 && vote)
						busy <= 1'b0;
					else if (bitn == stop_idx) begin
						busy <= 1'b0;
						done <= 1'b1;
						stop_ok <= vote;
						data <= sh;
					end else if (bitn == 4'h9)
						ninth <= vote;
					else if (bitn != 4'h0)
						sh <= {vote, sh[7:1]};
				end
				if (tk == `OVERSAMPLE_LAST)
					bitn <= bitn + 4'h1;
			end
		end
	end
endmodule // serial_rx_shift

// *** tb/serial_port_chk.sv ***
// Purpose: Port-level checks of the serial port block
// Assumes: APB master holds each request until pready
// Notes: Bound to the top module after endmodule
`timescale 1ns/1ns
module serial_port_chk (
	input logic ref_clk,
	input logic nrst,
	input logic psel,
	input logic penable,
	input logic [7:0] paddr,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr,
	input logic rxd_out,
	input logic rxd_oe,
	input logic txd_out,
	input logic irq
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	chk_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("pready not in second access cycle");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error response malformed");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer cycle");
	chk_unmapped_err: assert property (pready && paddr > 8'h20 |-> pslverr)
		else $error("unmapped access not refused");
	chk_mapped_ok: assert property (pready && paddr <= 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped access refused");
	chk_rxd_idle_high: assert property (!rxd_oe |-> rxd_out)
		else $error("rxd data driven outside shift mode");
	chk_reset_quiet: assert property ($rose(nrst) |-> !irq && txd_out && !rxd_oe)
		else $error("outputs not idle after reset");
	chk_irq_read_clear: assert property (pready && paddr == 8'h1c |-> ##2 !irq)
		else $error("irq stays after status read");
	cov_err: cover property (pslverr);
	cov_irq: cover property ($rose(irq));
	cov_shift: cover property ($rose(rxd_oe));
endmodule // serial_port_chk

bind serial_port_control_flags serial_port_chk u_serial_port_chk (.ref_clk(ref_clk),
	.nrst(nrst), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
	.txd_out(txd_out), .irq(irq));

// *** tb/serial_node_model.sv ***
// Purpose: Remote serial node sending and capturing UART frames
// Assumes: Bit time of bclk clocks, line idles at mark
// Notes: Frame carries nine bits when nine is set
`timescale 1ns/1ns
module serial_node_model (
	input logic ref_clk,
	input logic send,
	input logic nine,
	input logic [8:0] frame,
	input logic stop,
	input logic [7:0] bclk,
	input logic listen,
	input logic txd,
	output logic line = 1'h1,
	output logic nbusy = 1'h0,
	output logic rbusy = 1'h0,
	output logic [8:0] cap = 9'h0
);
	integer i;
	integer j;
	always @(posedge ref_clk) begin
		if (send) begin
			nbusy <= 1'h1;
			line <= 1'h0;
			repeat (bclk) @(posedge ref_clk);
			for (i = 0; i < 8 + nine; i = i + 1) begin
				line <= frame[i];
				repeat (bclk) @(posedge ref_clk);
			end
			line <= stop;
			repeat (bclk) @(posedge ref_clk);
			line <= 1'h1;
			nbusy <= 1'h0;
		end
	end
	// Samples each data bit at its middle
	always @(posedge ref_clk) begin
		if (listen && !txd) begin
			rbusy <= 1'h1;
			repeat (bclk / 2) @(posedge ref_clk);
			for (j = 0; j < 8 + nine; j = j + 1) begin
				repeat (bclk) @(posedge ref_clk);
				cap[j] <= txd;
			end
			repeat (bclk) @(posedge ref_clk);
			rbusy <= 1'h0;
		end
	end
endmodule // serial_node_model

// *** tb/serial_port_control_flags_tb_top.sv ***
// Purpose: Self-checking bench of the serial port control block
// Assumes: Register map of serial_port_regs.vh
// Notes: Double rate and reload ff give 16 clocks a bit
`timescale 1ns/1ns
`include "serial_port_regs.vh"
module serial_port_control_flags_tb_top;
	typedef struct packed {
		logic [7:0] ctl;
		logic [8:0] frame;
		logic stop;
		logic [7:0] mask;
		logic [7:0] exp;
		logic [2:0] st;
	} row_t;
	logic ref_clk = 1'h0;
	logic nrst = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic send = 1'h0;
	logic listen = 1'h0;
	logic nine = 1'h0;
	logic stop = 1'h1;
	logic [8:0] frame = 9'h0;
	logic [7:0] bclk = 8'h10;
	logic [7:0] sh_cap = 8'h0;
	logic txd_d = 1'h1;
	logic [31:0] r;
	logic e;
	wire [31:0] prdata;
	wire [8:0] cap;
	wire pready, pslverr, rxd_out, rxd_oe, txd_out, irq, line, nbusy, rbusy;
	wire rxd_in = rxd_oe ? rxd_out : line;
	integer n_mismatch = 0;
	integer n_compared = 0;
	integer cyc = 0;
	integer i;
	integer k;
	row_t rows [11];
	serial_port_control_flags u_serial_port_control_flags (.ref_clk(ref_clk), .nrst(nrst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd_in(rxd_in),
		.rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out), .irq(irq));
	serial_node_model u_serial_node_model (.ref_clk(ref_clk), .send(send), .nine(nine),
		.frame(frame), .stop(stop), .bclk(bclk), .listen(listen), .txd(txd_out),
		.line(line), .nbusy(nbusy), .rbusy(rbusy), .cap(cap));
	always #25 ref_clk = ~ref_clk;
	task tally_and_finish;
		begin
			if (n_mismatch == 0 && n_compared > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task cmp_data(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		begin
			n_compared = n_compared + 1;
			if (((got ^ exp) & m) !== 32'h0) begin
				n_mismatch = n_mismatch + 1;
				$display("[FAIL] %0t data %h expected %h", $time, got, exp);
			end
		end
	endtask
	task cmp_bit(input logic got, input logic exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
			end
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		begin
			psel <= 1'h1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge ref_clk);
			penable <= 1'h1;
			@(posedge ref_clk);
			while (pready !== 1'h1) @(posedge ref_clk);
			r = prdata;
			e = pslverr;
			psel <= 1'h0;
			penable <= 1'h0;
			@(posedge ref_clk);
		end
	endtask
	task poll(input integer b);
		begin
			k = 0;
			bus(1'h0, `OFF_SERIAL_PORT_CONTROL, 32'h0);
			while (r[b] !== 1'h1 && k < 300) begin
				bus(1'h0, `OFF_SERIAL_PORT_CONTROL, 32'h0);
				k = k + 1;
			end
			cmp_bit(r[b], 1'h1);
		end
	endtask
	task send_frame;
		begin
			send <= 1'h1;
			@(posedge ref_clk);
			send <= 1'h0;
			@(posedge ref_clk);
			while (nbusy) @(posedge ref_clk);
			repeat (4) @(posedge ref_clk);
		end
	endtask
	// Shift-mode bits taken at each rising shift clock
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		txd_d <= txd_out;
		if (rxd_oe && txd_out && !txd_d)
			sh_cap <= {rxd_out, sh_cap[7:1]};
		if (cyc == 30000) begin
			n_mismatch = n_mismatch + 1;
			tally_and_finish;
		end
	end
	initial begin
		rows[0] = {8'h50, 9'h05a, 1'h1, 8'hff, 8'h55, 3'h2};
		rows[1] = {8'h50, 9'h0a5, 1'h0, 8'hff, 8'h51, 3'h6};
		rows[2] = {8'h70, 9'h03d, 1'h1, 8'hfb, 8'h71, 3'h2};
		rows[3] = {8'h70, 9'h03e, 1'h1, 8'hfb, 8'h70, 3'h0};
		rows[4] = {8'h70, 9'h03c, 1'h0, 8'hfb, 8'h70, 3'h4};
		rows[5] = {8'hb0, 9'h13c, 1'h1, 8'hff, 8'hb5, 3'h2};
		rows[6] = {8'hb0, 9'h03c, 1'h1, 8'hfb, 8'hb0, 3'h0};
		rows[7] = {8'hb0, 9'h111, 1'h1, 8'hfb, 8'hb0, 3'h0};
		rows[8] = {8'hf0, 9'h1ff, 1'h1, 8'hff, 8'hf5, 3'h2};
		rows[9] = {8'hd0, 9'h000, 1'h1, 8'hff, 8'hd1, 3'h2};
		rows[10] = {8'h80, 9'h155, 1'h1, 8'hfb, 8'h80, 3'h0};
		repeat (8) @(posedge ref_clk);
		nrst <= 1'h1;
		@(posedge ref_clk);
		for (i = 0; i < 9; i = i + 1) begin
			bus(1'h0, {i[5:0], 2'h0}, 32'h0);
			cmp_data(r, 32'h0, 32'hff);
		end
		bus(1'h0, 8'h24, 32'h0);
		cmp_bit(e, 1'h1);
		bus(1'h1, `OFF_POWER_CONTROL, 32'h80);
		bus(1'h1, `OFF_BAUD_RELOAD, 32'hff);
		bus(1'h1, `OFF_OWN_ADDR, 32'h3c);
		bus(1'h1, `OFF_ADDR_MASK, 32'h01);
		bus(1'h1, `OFF_BCAST_ADDR, 32'hff);
		// Reload value only takes over at the first counter overflow
		repeat (256) @(posedge ref_clk);
		for (i = 0; i < 11; i = i + 1) begin
			bus(1'h1, `OFF_SERIAL_PORT_CONTROL, {24'h0, rows[i].ctl});
			bus(1'h0, `OFF_INT_STATUS, 32'h0);
			nine <= rows[i].ctl[7];
			frame <= rows[i].frame;
			stop <= rows[i].stop;
			send_frame;
			bus(1'h0, `OFF_SERIAL_PORT_CONTROL, 32'h0);
			cmp_data(r, {24'h0, rows[i].exp}, {24'h0, rows[i].mask});
			bus(1'h0, `OFF_INT_STATUS, 32'h0);
			cmp_data(r, {29'h0, rows[i].st}, 32'h7);
			if (rows[i].st[1]) begin
				bus(1'h0, `OFF_SERIAL_BUFFER, 32'h0);
				cmp_data(r, {23'h0, rows[i].frame}, 32'hff);
			end
		end
		bus(1'h1, `OFF_POWER_CONTROL, 32'hc0);
		bus(1'h0, `OFF_SERIAL_PORT_CONTROL, 32'h0);
		cmp_data(r, 32'h80, 32'h80);
		bus(1'h1, `OFF_SERIAL_PORT_CONTROL, 32'h0);
		bus(1'h0, `OFF_SERIAL_PORT_CONTROL, 32'h0);
		cmp_data(r, 32'h0, 32'h80);
		bus(1'h1, `OFF_POWER_CONTROL, 32'h80);
		bus(1'h1, `OFF_INT_MASK, 32'h0);
		bus(1'h1, `OFF_SERIAL_PORT_CONTROL, 32'h50);
		nine <= 1'h0;
		frame <= 9'h042;
		stop <= 1'h1;
		send_frame;
		cmp_bit(irq, 1'h0);
		bus(1'h1, `OFF_INT_MASK, 32'h2);
		repeat (2) @(posedge ref_clk);
		cmp_bit(irq, 1'h1);
		bus(1'h0, `OFF_INT_STATUS, 32'h0);
		cmp_data(r, 32'h2, 32'h7);
		repeat (2) @(posedge ref_clk);
		cmp_bit(irq, 1'h0);
		bus(1'h1, `OFF_POWER_CONTROL, 32'h0);
		listen <= 1'h1;
		nine <= 1'h1;
		bclk <= 8'h20;
		bus(1'h1, `OFF_SERIAL_PORT_CONTROL, 32'h88);
		bus(1'h1, `OFF_SERIAL_BUFFER, 32'h96);
		poll(1);
		cmp_bit(rbusy, 1'h1);
		cmp_bit(txd_out, 1'h1);
		while (rbusy) @(posedge ref_clk);
		cmp_data({23'h0, cap}, 32'h196, 32'h1ff);
		listen <= 1'h0;
		// Let the stop bit finish before the mode changes
		repeat (24) @(posedge ref_clk);
		bus(1'h1, `OFF_SERIAL_PORT_CONTROL, 32'h0);
		bus(1'h1, `OFF_SERIAL_BUFFER, 32'ha5);
		poll(1);
		cmp_data({24'h0, sh_cap}, 32'ha5, 32'hff);
		bus(1'h1, `OFF_SERIAL_PORT_CONTROL, 32'h10);
		poll(0);
		bus(1'h0, `OFF_SERIAL_BUFFER, 32'h0);
		cmp_data(r, 32'hff, 32'hff);
		nrst <= 1'h0;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'h1;
		@(posedge ref_clk);
		bus(1'h0, `OFF_SERIAL_PORT_CONTROL, 32'h0);
		cmp_data(r, 32'h0, 32'hff);
		tally_and_finish;
	end
endmodule // serial_port_control_flags_tb_top
